//--- core/pixel_chain_driver.sv
// Purpose: Two-line driver for chains of addressable pixels
// Assumes: User logic on clk supplies colour bytes per pixel
// Notes: Onboard line prepends four onboard words; header line does not
`timescale 1ns/1ns
`include "pixel_chain_map.svh"
module pixel_chain_driver #(
    parameter int MAX_EXT_PIXELS = 256,
    parameter int CNT_W = 10,
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    // Onboard chain frame request
    input wire logic onboard_start,
    input wire logic [CNT_W-1:0] onboard_ext_count,
    output logic onboard_busy,
    // Header chain frame request
    input wire logic header_start,
    input wire logic [CNT_W-1:0] header_count,
    output logic header_busy,
    // Colour stream for onboard line
    input wire logic [7:0] onboard_green,
    input wire logic [7:0] onboard_red,
    input wire logic [7:0] onboard_blue,
    input wire logic onboard_valid,
    output logic onboard_ready,
    // Colour stream for header line
    input wire logic [7:0] header_green,
    input wire logic [7:0] header_red,
    input wire logic [7:0] header_blue,
    input wire logic header_valid,
    output logic header_ready,
    // Serial lines
    output logic onboard_pixel_line,
    output logic header_pixel_line
);
    import pixel_chain_pkg::*;

    // ----------------------------------------
    // Per-line request bookkeeping
    // ----------------------------------------
    // Index 0 is the onboard line, index 1 the header line
    logic [1:0] start_in;
    logic [CNT_W-1:0] count_in [2];
    logic [`PIXEL_BITS-1:0] word_in [2];
    logic [1:0] valid_in;
    logic [1:0] ready_out;
    logic [1:0] line_wire;
    logic [1:0] busy_wire;
    logic [1:0] line_reg;  // Output line flops
    logic [1:0] busy_reg;  // Frame in progress flags
    logic [1:0] ready_reg;  // Registered acceptance

    assign start_in = {header_start, onboard_start};
    assign count_in[0] = onboard_ext_count;
    assign count_in[1] = header_count;
    assign valid_in = {header_valid, onboard_valid};
    // Green first, then red, then blue
    assign word_in[0] = {onboard_green, onboard_red, onboard_blue};
    assign word_in[1] = {header_green, header_red, header_blue};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : lane
            logic active_reg;  // Frame accepted, words pending
            logic [CNT_W-1:0] ext_left_reg;  // External pixel words still to queue
            logic [2:0] lead_left_reg;  // Onboard words still to queue
            logic [`PIXEL_BITS-1:0] fifo_in;
            logic fifo_in_valid;
            logic fifo_in_ready;
            logic [`PIXEL_BITS:0] fifo_out;
            logic fifo_out_valid;
            logic fifo_out_ready;
            logic enc_busy;
            logic last_word;
            logic user_take;

            // Total words to go decides the frame-ending word
            assign last_word = (ext_left_reg + CNT_W'(lead_left_reg)) == CNT_W'(1);
            assign fifo_in = word_in[g];
            // Onboard line also takes words for the four leading pixels
            assign fifo_in_valid = active_reg && valid_in[g];
            assign user_take = fifo_in_valid && fifo_in_ready;

            // ----------------------------------------
            // Frame admission and word counting
            // ----------------------------------------
            // Count is latched at start so it may change mid frame
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    active_reg <= 1'b0;
                    ext_left_reg <= '0;
                    lead_left_reg <= '0;
                end else if (!active_reg) begin
                    // New frame only when the line is idle and gap done
                    if (start_in[g] && !enc_busy && !fifo_out_valid) begin
                        ext_left_reg <= count_in[g];
                        // Header line carries no onboard words
                        lead_left_reg <= (g == 0) ? 3'(`ONBOARD_PIXELS) : 3'd0;
                        active_reg <= ((g == 0) ? 1'b1 : (count_in[g] != '0));
                    end
                end else if (user_take) begin
                    // Leading onboard words are consumed before external ones
                    if (lead_left_reg != '0) begin
                        lead_left_reg <= lead_left_reg - 1'b1;
                    end else begin
                        ext_left_reg <= ext_left_reg - 1'b1;
                    end
                    if (last_word) begin
                        active_reg <= 1'b0;
                    end
                end
            end

            // Word plus its end-of-frame mark travel together
            pixel_fifo #(
                .WIDTH(`PIXEL_BITS + 1),
                .DEPTH(FIFO_DEPTH)
            ) u_fifo (
                .clk(clk),
                .rst(rst),
                .in_data({last_word, fifo_in}),
                .in_valid(fifo_in_valid),
                .in_ready(fifo_in_ready),
                .out_data(fifo_out),
                .out_valid(fifo_out_valid),
                .out_ready(fifo_out_ready)
            );

            pixel_line_encoder u_enc (
                .clk(clk),
                .rst(rst),
                .word_data(fifo_out[`PIXEL_BITS-1:0]),
                .word_valid(fifo_out_valid),
                .word_ready(fifo_out_ready),
                .word_last(fifo_out[`PIXEL_BITS]),
                .line_out(line_wire[g]),
                .busy(enc_busy)
            );

            assign busy_wire[g] = active_reg || fifo_out_valid || enc_busy;
            // Ready is a flop, so it lags the FIFO by one cycle; the source
            // sees it together with valid on the next cycle
            assign ready_out[g] = active_reg && fifo_in_ready;
        end
    endgenerate

    // ----------------------------------------
    // Output flops
    // ----------------------------------------
    // Lines re-registered: outputs come straight from flops; low in reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            line_reg <= 2'b00;
            busy_reg <= 2'b00;
            ready_reg <= 2'b00;
        end else begin
            line_reg <= line_wire;
            busy_reg <= busy_wire;
            ready_reg <= ready_out;
        end
    end

    assign onboard_pixel_line = line_reg[0];
    assign header_pixel_line = line_reg[1];
    assign onboard_busy = busy_reg[0];
    assign header_busy = busy_reg[1];
    assign onboard_ready = ready_reg[0];
    assign header_ready = ready_reg[1];
endmodule

//--- core/pixel_fifo.sv
// Purpose: Small flip-flop FIFO for pixel words
// Assumes: Single clock, async active-high reset
// Notes: Full and empty are exact; no overwrite on full
`timescale 1ns/1ns
module pixel_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_reg [DEPTH];  // Storage entries
    logic [AW-1:0] wr_reg;  // Write index
    logic [AW-1:0] rd_reg;  // Read index
    logic [AW:0] count_reg;  // Occupancy
    logic push;
    logic pop;

    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_reg];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // ----------------------------------------
    // Storage write
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (push) begin
            mem_reg[wr_reg] <= in_data;
        end
    end

    // ----------------------------------------
    // Pointers and count
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_reg <= '0;
            rd_reg <= '0;
            count_reg <= '0;
        end else begin
            // Wrap explicitly so non power of two depths work
            if (push) begin
                wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
            end
            if (pop) begin
                rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

//--- core/pixel_line_encoder.sv
// Purpose: Turns pixel words into the self-timed pulse line
// Assumes: Words arrive valid/ready; word_last marks last word
// Notes: Line low in reset, gap and during every low phase
`timescale 1ns/1ns
`include "pixel_chain_map.svh"
module pixel_line_encoder (
    input wire logic clk,
    input wire logic rst,
    input wire logic [`PIXEL_BITS-1:0] word_data,
    input wire logic word_valid,
    output logic word_ready,
    input wire logic word_last,
    output logic line_out,
    output logic busy
);
    import pixel_chain_pkg::*;

    line_state_t state_reg;  // Line phase
    logic [`PIXEL_BITS-1:0] shift_reg;  // Bits still to send
    logic [4:0] bit_reg;  // Bits left in word
    logic last_reg;  // Current word ends frame
    logic [15:0] timer_reg;  // Phase cycle counter
    logic line_reg;  // Registered line level

    assign line_out = line_reg;
    assign word_ready = (state_reg == LINE_GAP) && (timer_reg == '0);
    assign busy = (state_reg != LINE_GAP) || (timer_reg != '0);

    // ----------------------------------------
    // Bit sequencing, MSB first, level by pulse width
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LINE_GAP;
            shift_reg <= '0;
            bit_reg <= '0;
            last_reg <= 1'b0;
            timer_reg <= '0;
            line_reg <= 1'b0;  // Idle low from reset
        end else begin
            unique case (state_reg)
                LINE_GAP: begin
                    // Hold low; no new frame before gap elapses
                    line_reg <= 1'b0;
                    if (timer_reg != '0) begin
                        timer_reg <= timer_reg - 1'b1;
                    end else if (word_valid) begin
                        shift_reg <= word_data;
                        last_reg <= word_last;
                        bit_reg <= 5'(`PIXEL_BITS - 1);
                        state_reg <= LINE_HIGH;
                        line_reg <= 1'b1;
                        // High width carries bit value
                        timer_reg <= word_data[`PIXEL_BITS-1] ? 16'(`ONE_HIGH_CYC - 1) : 16'(`ZERO_HIGH_CYC - 1);
                    end
                end
                LINE_HIGH: begin
                    if (timer_reg != '0) begin
                        timer_reg <= timer_reg - 1'b1;
                    end else begin
                        line_reg <= 1'b0;
                        state_reg <= LINE_LOW;
                        timer_reg <= shift_reg[`PIXEL_BITS-1] ? 16'(`ONE_LOW_CYC - 1) : 16'(`ZERO_LOW_CYC - 1);
                    end
                end
                LINE_LOW: begin
                    if (timer_reg != '0) begin
                        timer_reg <= timer_reg - 1'b1;
                    end else if (bit_reg != '0) begin
                        // Next bit of same word, MSB first
                        shift_reg <= {shift_reg[`PIXEL_BITS-2:0], 1'b0};
                        bit_reg <= bit_reg - 1'b1;
                        state_reg <= LINE_HIGH;
                        line_reg <= 1'b1;
                        timer_reg <= shift_reg[`PIXEL_BITS-2] ? 16'(`ONE_HIGH_CYC - 1) : 16'(`ZERO_HIGH_CYC - 1);
                    end else begin
                        // Word done; last word opens the frame gap
                        state_reg <= LINE_GAP;
                        timer_reg <= last_reg ? 16'(`FRAME_END_LOW_CYC) : '0;
                    end
                end
            endcase
        end
    end
endmodule

//--- shared/pixel_chain_map.svh
// Purpose: Constants for the addressable pixel chain driver
// Assumes: 20 MHz clock, 50 ns period
// Notes: Times are in ns; cycle counts derive from them
// Function
// - Each pixel word is 24 bits, three bytes.
// - Green, red, blue order, MSB first.
// - Zero bit: high 220-380ns, low 580ns-1us.
// - One bit: high 580ns-1us, low 220-420ns.
// - Frame gap low for over 280us.
// - Single line NRZ, value in pulse widths.
// - Onboard pixels in one chain, chain order.
// - Onboard line sends four onboard words first.
// - Header line sends external words only.
// - Two independent outputs, each own frame.
// - Pixel count configurable, not fixed.
`ifndef PIXEL_CHAIN_MAP_SVH
`define PIXEL_CHAIN_MAP_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_PERIOD_NS 50
// Targets sit inside the allowed windows with margin
`define ZERO_HIGH_TIME_NS 300
`define ZERO_LOW_TIME_NS 800
`define ONE_HIGH_TIME_NS 800
`define ONE_LOW_TIME_NS 300
`define FRAME_END_LOW_TIME_NS 300000
`define ZERO_HIGH_CYC (`ZERO_HIGH_TIME_NS / `CLK_PERIOD_NS)
`define ZERO_LOW_CYC (`ZERO_LOW_TIME_NS / `CLK_PERIOD_NS)
`define ONE_HIGH_CYC (`ONE_HIGH_TIME_NS / `CLK_PERIOD_NS)
`define ONE_LOW_CYC (`ONE_LOW_TIME_NS / `CLK_PERIOD_NS)
`define FRAME_END_LOW_CYC ((`FRAME_END_LOW_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 1)

// ----------------------------------------
// Pixel word layout
// ----------------------------------------
`define PIXEL_BITS 24
`define GREEN_MSB 23
`define GREEN_LSB 16
`define RED_MSB 15
`define RED_LSB 8
`define BLUE_MSB 7
`define BLUE_LSB 0
`define ONBOARD_PIXELS 4
`define FIFO_DEPTH 4

`endif

//--- shared/pixel_chain_pkg.sv
// Purpose: Types for the pixel chain driver
// Assumes: Nothing beyond the constants header
// Notes: Holds the line encoder states
package pixel_chain_pkg;
    // Serial line phases
    typedef enum logic [1:0] {
        LINE_GAP,
        LINE_HIGH,
        LINE_LOW
    } line_state_t;
    // Which stream feeds a line
    typedef logic [1:0] line_sel_t;
endpackage

//--- test/pixel_chain_model.sv
// Purpose: Behavioural chain of pixels listening on one line
// Assumes: 50 ns clock; decodes by high-pulse length only
// Notes: Passive, so it can only report what the line carried
`timescale 1ns/1ns
module pixel_chain_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic line,
    output logic [23:0] word,
    output logic got,
    output logic [23:0] kept
);
    logic [13:0] hi_reg; // High run length
    logic [13:0] lo_reg; // Low run length
    logic [23:0] sr_reg; // Bits of the current word
    logic [4:0] bits_reg; // Bit count within word
    logic first_reg; // Next word is the first of a frame
    // ----------------------------------------
    // Decoder: threshold halfway between 300 and 800 ns
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {hi_reg, lo_reg, sr_reg, bits_reg, word, kept, got} <= '0;
            first_reg <= 1'b1;
        end else begin
            got <= 1'b0;
            hi_reg <= line ? hi_reg + 14'h0001 : 14'h0000;
            lo_reg <= line ? 14'h0000 : (lo_reg == 14'h3FFF ? lo_reg : lo_reg + 14'h0001);
            // A falling edge closes one bit; no clock, width is the value
            if (!line && hi_reg != 14'h0000) begin
                sr_reg <= {sr_reg[22:0], hi_reg > 14'h000A};
                if (bits_reg == 5'h17) begin
                    word <= {sr_reg[22:0], hi_reg > 14'h000A};
                    got <= 1'b1;
                    bits_reg <= 5'h00;
                    first_reg <= 1'b0;
                    // First pixel latches its word; the rest travel on
                    if (first_reg) begin
                        kept <= {sr_reg[22:0], hi_reg > 14'h000A};
                    end
                end else begin
                    bits_reg <= bits_reg + 5'h01;
                end
            end
            // Long low ends the frame
            if (lo_reg == 14'd5600) begin
                bits_reg <= 5'h00;
                first_reg <= 1'b1;
            end
        end
    end
endmodule

//--- test/pixel_chain_props.sv
// Purpose: Port-level checks on the two pixel lines of the chain driver
// Assumes: 50 ns clock, async active-high reset
// Notes: Low run-length counters saturate, so a long gap reads as a large value
`timescale 1ns/1ns
module pixel_chain_props #(
    parameter int CNT_W = 10
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic onboard_start,
    input wire logic onboard_busy,
    input wire logic onboard_ready,
    input wire logic header_start,
    input wire logic [CNT_W-1:0] header_count,
    input wire logic header_busy,
    input wire logic header_ready,
    input wire logic onboard_pixel_line,
    input wire logic header_pixel_line
);
    // ----------------------------------------
    // Run-length helpers, index 0 onboard, 1 header
    // ----------------------------------------
    wire [1:0] ln = {header_pixel_line, onboard_pixel_line};
    wire [1:0] bz = {header_busy, onboard_busy};
    wire [1:0] rd = {header_ready, onboard_ready};
    logic [13:0] hi_reg[2]; // High samples in the current run
    logic [13:0] lo_reg[2]; // Low samples; reset counts as a gap
    logic [1:0] short_reg; // Last high pulse was a zero bit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hi_reg <= '{14'h0000, 14'h0000};
            lo_reg <= '{14'h3FFF, 14'h3FFF};
            short_reg <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                hi_reg[i] <= ln[i] ? hi_reg[i] + 14'h0001 : 14'h0000;
                lo_reg[i] <= ln[i] ? 14'h0000 : (lo_reg[i] == 14'h3FFF ? lo_reg[i] : lo_reg[i] + 14'h0001);
                if (!ln[i] && hi_reg[i] != 14'h0000) begin
                    short_reg[i] <= hi_reg[i] < 14'h000A;
                end
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Per-line timing
    // ----------------------------------------
    for (genvar g = 0; g < 2; g++) begin : per_line
        chk_idle_low: assert property (!bz[g] |-> !ln[g])
            else $error("line high while idle");
        chk_high_width: assert property ($fell(ln[g]) |-> hi_reg[g] inside {[5:7], [12:20]})
            else $error("high pulse width out of window");
        chk_low_width: assert property ($rose(ln[g]) |-> lo_reg[g] > 14'd5600 ||
            (short_reg[g] ? lo_reg[g] inside {[12:20]} : lo_reg[g] inside {[5:8]}))
            else $error("low time does not match bit");
        chk_gap_busy: assert property ($fell(bz[g]) |-> lo_reg[g] > 14'd5600)
            else $error("busy ended before frame gap");
        chk_ready_busy: assert property (rd[g] |-> bz[g])
            else $error("word taken outside a frame");
    end
    // Busy sits one flop behind the admission flop, so it shows two edges after the start edge
    chk_start_busy: assert property (onboard_start && !onboard_busy |-> ##2 onboard_busy)
        else $error("onboard start not taken");
    chk_hdr_start: assert property (header_start && !header_busy && header_count != '0 |-> ##2 header_busy)
        else $error("header start not taken");
    // Looked at two edges on, where a wrongly taken empty frame would first show as busy
    chk_count_zero: assert property (header_start && !header_busy && header_count == '0 |-> ##2 !header_busy)
        else $error("empty header frame started");
endmodule
bind pixel_chain_driver pixel_chain_props #(.CNT_W(CNT_W)) chk (.clk(clk), .rst(rst),
    .onboard_start(onboard_start), .onboard_busy(onboard_busy), .onboard_ready(onboard_ready),
    .header_start(header_start), .header_count(header_count), .header_busy(header_busy),
    .header_ready(header_ready), .onboard_pixel_line(onboard_pixel_line), .header_pixel_line(header_pixel_line));

//--- test/tb.sv
// Purpose: Self-checking bench for the two-line pixel chain driver
// Assumes: 20 MHz clock; words checked as decoded by the chain models
// Notes: Drivers queue expected words, monitors pop them
`timescale 1ns/1ns
`define CHECK(g, e) begin checks++; if ((g) !== (e)) begin miscompares++; \
    $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic st[2], vld[2]; // Start and valid per line
    logic [9:0] cnt[2]; // Frame counts
    logic [23:0] wd[2], ex[2], first[2]; // Words in, expected, first sent
    logic [23:0] q[2][$]; // Expected words per line
    wire [1:0] bz, rdy, ln, got;
    wire [23:0] wrd[2], kept[2];
    int miscompares = 0;
    int checks = 0;
    always #25 clk = ~clk;
    pixel_chain_driver dut (.clk(clk), .rst(rst),
        .onboard_start(st[0]), .onboard_ext_count(cnt[0]), .onboard_busy(bz[0]),
        .header_start(st[1]), .header_count(cnt[1]), .header_busy(bz[1]),
        .onboard_green(wd[0][23:16]), .onboard_red(wd[0][15:8]), .onboard_blue(wd[0][7:0]),
        .onboard_valid(vld[0]), .onboard_ready(rdy[0]),
        .header_green(wd[1][23:16]), .header_red(wd[1][15:8]), .header_blue(wd[1][7:0]),
        .header_valid(vld[1]), .header_ready(rdy[1]),
        .onboard_pixel_line(ln[0]), .header_pixel_line(ln[1]));
    // One model per line, since each line carries its own frame
    for (genvar g = 0; g < 2; g++) begin : mon
        pixel_chain_model m (.clk(clk), .rst(rst), .line(ln[g]), .word(wrd[g]), .got(got[g]), .kept(kept[g]));
        always @(posedge clk) begin
            if (got[g] === 1'b1) begin
                if (q[g].size() == 0) begin
                    miscompares++;
                    $display("ERROR %0t: unexpected word", $time);
                end else begin
                    ex[g] = q[g].pop_front();
                    `CHECK(wrd[g], ex[g])
                end
            end
        end
    end
    // Hold the word until ready shows, then drop valid for a cycle
    task automatic feed(input int ch, input logic [23:0] w);
        int n;
        n = 0;
        wd[ch] = w;
        vld[ch] = 1'b1;
        q[ch].push_back(w);
        do begin
            @(posedge clk);
            #2;
            n++;
        end while (rdy[ch] !== 1'b1 && n < 2000);
        if (n >= 2000) begin
            miscompares++;
            $display("ERROR %0t: word not taken", $time);
        end
        vld[ch] = 1'b0;
        @(posedge clk);
        #2;
    endtask
    // Whole frame; poke repeats start while busy, which must be ignored
    task automatic frame(input int ch, input int c, input int words, input bit poke);
        int n;
        logic [23:0] w;
        n = 0;
        cnt[ch] = c[9:0];
        st[ch] = 1'b1;
        @(posedge clk);
        #2;
        st[ch] = 1'b0;
        for (int i = 0; i < words; i++) begin
            w = (i == 1) ? 24'h000000 : (i == 2) ? 24'hFFFFFF : 24'($urandom);
            if (i == 0) first[ch] = w;
            feed(ch, w);
        end
        if (poke) begin
            st[ch] = 1'b1;
            @(posedge clk);
            #2;
            st[ch] = 1'b0;
        end
        while (bz[ch] !== 1'b0 && n < 20000) begin
            @(posedge clk);
            #2;
            n++;
        end
        `CHECK(bz[ch], 1'b0)
    endtask
    task automatic conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h07b2d852));
        st = '{1'b0, 1'b0};
        vld = '{1'b0, 1'b0};
        cnt = '{10'h000, 10'h000};
        wd = '{24'h000000, 24'h000000};
        repeat (6) @(posedge clk);
        #2 rst = 1'b0;
        // Both lines at once: four onboard plus two, and three on the header
        fork
            frame(0, 2, 6, 1'b1);
            frame(1, 3, 3, 1'b0);
        join
        $display("test concurrent frames done");
        cnt[1] = 10'h000;
        st[1] = 1'b1;
        @(posedge clk);
        #2 st[1] = 1'b0;
        repeat (3) @(posedge clk);
        #2;
        `CHECK(bz[1], 1'b0)
        $display("test empty header frame done");
        fork
            frame(0, 0, 4, 1'b0);
            frame(1, 1, 1, 1'b0);
        join
        repeat (5) @(posedge clk);
        `CHECK(q[0].size() + q[1].size(), 0)
        `CHECK(kept[0], first[0])
        `CHECK(kept[1], first[1])
        $display("test shortest frames done");
        conclude;
    end
    initial begin
        #(60000 * 50);
        miscompares++;
        $display("ERROR %0t: timeout", $time);
        conclude;
    end
endmodule
